// ===== verilog/cmrr_pkg.sv
// Package of constants and types for the move/rotate/return executor
package cmrr_pkg;
	localparam int CMRR_DATA_W = 8;
	localparam int CMRR_ADDR_W = 7;
	localparam int CMRR_PC_W = 13;
	localparam logic [6:0] CMRR_ADDR_MAX = 7'h7f;
	localparam logic [7:0] CMRR_ACC_RST = 8'h00;
	localparam logic [12:0] CMRR_PC_RST = 13'h0000;
	localparam logic CMRR_DEST_ACC = 1'b0;
	localparam logic CMRR_DEST_FILE = 1'b1;
	localparam logic [12:0] CMRR_PC_STEP = 13'h0001;
	localparam int CMRR_RET_CYCLES = 2;
	typedef enum logic [2:0] {
		CMRR_IDLE_OP,
		CMRR_COPY_FILE_OP,
		CMRR_IRQ_RETURN_OP,
		CMRR_LITERAL_RETURN_OP,
		CMRR_ROTATE_LEFT_OP,
		CMRR_ROTATE_RIGHT_OP
	} cmrr_op_t;
	typedef enum logic {
		CMRR_ST_EXEC,
		CMRR_ST_REFILL
	} cmrr_state_t;
endpackage

// ===== verilog/cmrr_alu.sv
// Combinational result and flag logic for copy and rotate operations
`timescale 1ns/1ns
`default_nettype none
module cmrr_alu
	import cmrr_pkg::*;
(
	input wire cmrr_op_t op,
	input wire logic [7:0] operand,
	input wire logic carry_in,
	output logic [7:0] result,
	output logic carry_out,
	output logic zero_out
);
	always_comb begin
		result = operand;
		carry_out = carry_in;
		unique case (op)
			CMRR_ROTATE_LEFT_OP: begin
				result = {operand[6:0], carry_in};
				carry_out = operand[7];
			end
			CMRR_ROTATE_RIGHT_OP: begin
				result = {carry_in, operand[7:1]};
				carry_out = operand[0];
			end
			default: begin
				result = operand;
				carry_out = carry_in;
			end
		endcase
		zero_out = (result == 8'h00);
	end
endmodule
`default_nettype wire

// ===== verilog/cmrr_exec.sv
// Executor for copy, idle, interrupt return, literal return and rotates
// Behaviour
// - copy file to accumulator or back to file
// - copy updates zero flag for either destination
// - irq return pops slot, sets allow, keeps flags
// - rotate left through carry, only carry changes
// - rotate right through carry, only carry changes
// - literal return loads accumulator, flags unchanged
// - literal return pops stack into program counter
// - literal return takes two instruction cycles
`timescale 1ns/1ns
`default_nettype none
module cmrr_exec
	import cmrr_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic op_valid,
	input wire cmrr_op_t op,
	input wire logic [6:0] file_addr,
	input wire logic dest_sel,
	input wire logic [7:0] literal,
	input wire logic [7:0] file_rdata,
	input wire logic [12:0] return_slot,
	input wire logic carry_in,
	input wire logic zero_in,
	output logic [6:0] file_raddr,
	output logic file_we,
	output logic [6:0] file_waddr,
	output logic [7:0] file_wdata,
	output logic [7:0] acc,
	output logic carry_we,
	output logic carry_out,
	output logic zero_we,
	output logic zero_out,
	output logic stack_pop,
	output logic global_irq_allow_set,
	output logic [12:0] pc,
	output logic busy
);
	cmrr_state_t state_r, state_nxt;
	logic file_we_r, file_we_nxt;
	logic [6:0] file_waddr_r, file_waddr_nxt;
	logic [7:0] file_wdata_r, file_wdata_nxt;
	logic [7:0] acc_r, acc_nxt;
	logic carry_we_r, carry_we_nxt;
	logic carry_r, carry_nxt;
	logic zero_we_r, zero_we_nxt;
	logic zero_r, zero_nxt;
	logic pop_r, pop_nxt;
	logic gia_r, gia_nxt;
	logic [12:0] pc_r, pc_nxt;
	logic busy_r, busy_nxt;
	logic [7:0] alu_result;
	logic alu_carry;
	logic alu_zero;

	cmrr_alu u_alu (
		.op(op),
		.operand(file_rdata),
		.carry_in(carry_in),
		.result(alu_result),
		.carry_out(alu_carry),
		.zero_out(alu_zero)
	);

	// Read port is combinational so the operand arrives this cycle
	assign file_raddr = file_addr & CMRR_ADDR_MAX;

	always_comb begin
		state_nxt = state_r;
		file_we_nxt = 1'b0;
		file_waddr_nxt = file_waddr_r;
		file_wdata_nxt = file_wdata_r;
		acc_nxt = acc_r;
		carry_we_nxt = 1'b0;
		carry_nxt = carry_r;
		zero_we_nxt = 1'b0;
		zero_nxt = zero_r;
		pop_nxt = 1'b0;
		gia_nxt = 1'b0;
		pc_nxt = pc_r;
		busy_nxt = 1'b0;
		unique case (state_r)
			CMRR_ST_REFILL: begin
				// Second cycle of a return: fetch redirected, no new op
				state_nxt = CMRR_ST_EXEC;
			end
			CMRR_ST_EXEC: begin
				if (op_valid) begin
					unique case (op)
						CMRR_IDLE_OP: begin
							pc_nxt = pc_r + CMRR_PC_STEP;
						end
						CMRR_COPY_FILE_OP,
						CMRR_ROTATE_LEFT_OP,
						CMRR_ROTATE_RIGHT_OP: begin
							pc_nxt = pc_r + CMRR_PC_STEP;
							if (dest_sel == CMRR_DEST_FILE) begin
								file_we_nxt = 1'b1;
								file_waddr_nxt = file_raddr;
								file_wdata_nxt = alu_result;
							end else begin
								acc_nxt = alu_result;
							end
							if (op == CMRR_COPY_FILE_OP) begin
								zero_we_nxt = 1'b1;
								zero_nxt = alu_zero;
							end else begin
								carry_we_nxt = 1'b1;
								carry_nxt = alu_carry;
							end
						end
						CMRR_IRQ_RETURN_OP: begin
							pc_nxt = return_slot;
							pop_nxt = 1'b1;
							gia_nxt = 1'b1;
							busy_nxt = 1'b1;
							state_nxt = CMRR_ST_REFILL;
						end
						CMRR_LITERAL_RETURN_OP: begin
							acc_nxt = literal;
							pc_nxt = return_slot;
							pop_nxt = 1'b1;
							busy_nxt = 1'b1;
							state_nxt = CMRR_ST_REFILL;
						end
						default: begin
							pc_nxt = pc_r + CMRR_PC_STEP;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= CMRR_ST_EXEC;
			file_we_r <= 1'b0;
			file_waddr_r <= 7'h00;
			file_wdata_r <= 8'h00;
			acc_r <= CMRR_ACC_RST;
			carry_we_r <= 1'b0;
			carry_r <= 1'b0;
			zero_we_r <= 1'b0;
			zero_r <= 1'b0;
			pop_r <= 1'b0;
			gia_r <= 1'b0;
			pc_r <= CMRR_PC_RST;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			file_we_r <= file_we_nxt;
			file_waddr_r <= file_waddr_nxt;
			file_wdata_r <= file_wdata_nxt;
			acc_r <= acc_nxt;
			carry_we_r <= carry_we_nxt;
			carry_r <= carry_nxt;
			zero_we_r <= zero_we_nxt;
			zero_r <= zero_nxt;
			pop_r <= pop_nxt;
			gia_r <= gia_nxt;
			pc_r <= pc_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign file_we = file_we_r;
	assign file_waddr = file_waddr_r;
	assign file_wdata = file_wdata_r;
	assign acc = acc_r;
	assign carry_we = carry_we_r;
	assign carry_out = carry_r;
	assign zero_we = zero_we_r;
	assign zero_out = zero_r;
	assign stack_pop = pop_r;
	assign global_irq_allow_set = gia_r;
	assign pc = pc_r;
	assign busy = busy_r;

	// Assertions
	logic exec_ok;
	assign exec_ok = op_valid && state_r == CMRR_ST_EXEC;

	sequence s_ret_taken;
		exec_ok && op == CMRR_LITERAL_RETURN_OP;
	endsequence
	sequence s_ret_done;
		stack_pop && busy ##1 !busy;
	endsequence

	AST_COPY_ACC: assert property (@(posedge clock) disable iff (!rst_n)
		exec_ok && op == CMRR_COPY_FILE_OP && dest_sel == CMRR_DEST_ACC
		|=> acc == $past(file_rdata) && !file_we)
		else $error("copy to accumulator wrong");
	AST_COPY_FILE: assert property (@(posedge clock) disable iff (!rst_n)
		exec_ok && op == CMRR_COPY_FILE_OP && dest_sel == CMRR_DEST_FILE
		|=> file_we && file_wdata == $past(file_rdata) && $stable(acc))
		else $error("copy to file wrong");
	AST_COPY_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
		exec_ok && op == CMRR_COPY_FILE_OP
		|=> zero_we && zero_out == ($past(file_rdata) == 8'h00) && !carry_we)
		else $error("copy zero flag wrong");
	AST_IRQ_RET: assert property (@(posedge clock) disable iff (!rst_n)
		exec_ok && op == CMRR_IRQ_RETURN_OP
		|=> pc == $past(return_slot) && stack_pop && global_irq_allow_set
		&& !zero_we && !carry_we)
		else $error("irq return wrong");
	AST_ROT_LEFT: assert property (@(posedge clock) disable iff (!rst_n)
		exec_ok && op == CMRR_ROTATE_LEFT_OP
		|=> carry_we && !zero_we && carry_out == $past(file_rdata[7])
		&& (file_we ? file_wdata[0] : acc[0]) == $past(carry_in))
		else $error("rotate left wrong");
	AST_ROT_RIGHT: assert property (@(posedge clock) disable iff (!rst_n)
		exec_ok && op == CMRR_ROTATE_RIGHT_OP
		|=> carry_we && !zero_we && carry_out == $past(file_rdata[0])
		&& (file_we ? file_wdata[7] : acc[7]) == $past(carry_in))
		else $error("rotate right wrong");
	AST_LIT_ACC: assert property (@(posedge clock) disable iff (!rst_n)
		s_ret_taken |=> acc == $past(literal) && !zero_we && !carry_we)
		else $error("literal return accumulator wrong");
	AST_LIT_POP: assert property (@(posedge clock) disable iff (!rst_n)
		s_ret_taken |=> pc == $past(return_slot) && stack_pop ##1 !stack_pop)
		else $error("literal return pop wrong");
	AST_LIT_TWO: assert property (@(posedge clock) disable iff (!rst_n)
		s_ret_taken |=> s_ret_done)
		else $error("literal return not two cycles");
	AST_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
		exec_ok && op == CMRR_IDLE_OP
		|=> pc == $past(pc) + CMRR_PC_STEP && $stable(acc) && !file_we
		&& !stack_pop && !busy && !zero_we && !carry_we)
		else $error("idle changed state");
endmodule
`default_nettype wire

// ===== verification/cmrr_far_model.sv
// Far-side model: file registers, flag owner and return stack
`timescale 1ns/1ns
`default_nettype none
module cmrr_far_model (
	input wire logic clock,
	input wire logic [6:0] file_raddr,
	input wire logic file_we,
	input wire logic [6:0] file_waddr,
	input wire logic [7:0] file_wdata,
	input wire logic carry_we,
	input wire logic carry_out,
	input wire logic zero_we,
	input wire logic zero_out,
	input wire logic stack_pop,
	output logic [7:0] file_rdata,
	output logic [12:0] return_slot,
	output logic carry_in,
	output logic zero_in
);
	logic [7:0] mem [128];
	logic [12:0] stk [4];
	logic [1:0] sp;
	initial begin
		sp = 2'h0;
		carry_in = 1'b0;
		zero_in = 1'b0;
	end
	assign file_rdata = mem[file_raddr];
	assign return_slot = stk[sp];
	always @(posedge clock) begin
		if (file_we) mem[file_waddr] <= file_wdata;
		if (carry_we) carry_in <= carry_out;
		if (zero_we) zero_in <= zero_out;
		if (stack_pop) sp <= sp + 2'h1;
	end
endmodule
`default_nettype wire

// ===== verification/tb_cpu_move_rotate_return_ops.sv
// Testbench for the move/rotate/return executor
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_move_rotate_return_ops
	import cmrr_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic op_valid = 1'b0;
	cmrr_op_t op = CMRR_IDLE_OP;
	logic [6:0] file_addr = 7'h00;
	logic dest_sel = 1'b0;
	logic [7:0] literal = 8'h00;
	logic [7:0] file_rdata, file_wdata, acc;
	logic [12:0] return_slot, pc, p;
	logic carry_in, zero_in, file_we, carry_we, carry_out, zero_we, zero_out;
	logic stack_pop, global_irq_allow_set, busy;
	logic [6:0] file_raddr, file_waddr;
	int err_count = 0;
	int num_checks = 0;
	always #50 clock = ~clock;
	cmrr_exec uut (.clock(clock), .rst_n(rst_n), .op_valid(op_valid), .op(op),
		.file_addr(file_addr), .dest_sel(dest_sel), .literal(literal),
		.file_rdata(file_rdata), .return_slot(return_slot),
		.carry_in(carry_in), .zero_in(zero_in), .file_raddr(file_raddr),
		.file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
		.acc(acc), .carry_we(carry_we), .carry_out(carry_out),
		.zero_we(zero_we), .zero_out(zero_out), .stack_pop(stack_pop),
		.global_irq_allow_set(global_irq_allow_set), .pc(pc), .busy(busy));
	cmrr_far_model far (.clock(clock), .file_raddr(file_raddr),
		.file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
		.carry_we(carry_we), .carry_out(carry_out), .zero_we(zero_we),
		.zero_out(zero_out), .stack_pop(stack_pop), .file_rdata(file_rdata),
		.return_slot(return_slot), .carry_in(carry_in), .zero_in(zero_in));
	// Wide enough for the longest packed group of outputs compared at once
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Presents one op; returns in the cycle after it is taken
	task automatic go(cmrr_op_t o, logic [6:0] a, logic d, logic [7:0] k);
		@(posedge clock);
		#10 op = o;
		file_addr = a;
		dest_sel = d;
		literal = k;
		op_valid = 1'b1;
		p = pc;
		@(posedge clock);
		#10 op_valid = 1'b0;
	endtask
	task automatic t_copy;
		far.mem[5] = 8'h00;
		far.mem[127] = 8'h5a;
		go(CMRR_COPY_FILE_OP, 7'h05, 1'b1, 8'h00);
		chk({file_we, file_waddr, file_wdata}, {1'b1, 7'h05, 8'h00});
		chk({zero_we, zero_out, carry_we}, 3'b110);
		chk(pc, p + CMRR_PC_STEP);
		go(CMRR_COPY_FILE_OP, CMRR_ADDR_MAX, 1'b0, 8'h00);
		chk({file_we, acc}, {1'b0, 8'h5a});
		chk(file_raddr, CMRR_ADDR_MAX);
		chk({zero_we, zero_out}, 2'b10);
		$display("copy test done");
	endtask
	task automatic t_rot;
		far.mem[3] = 8'h80;
		far.carry_in = 1'b1;
		go(CMRR_ROTATE_LEFT_OP, 7'h03, 1'b1, 8'h00);
		chk({file_we, file_wdata, carry_we, carry_out}, 11'h407);
		chk({zero_we, pc}, {1'b0, p + CMRR_PC_STEP});
		go(CMRR_ROTATE_RIGHT_OP, 7'h03, 1'b0, 8'h00);
		chk({file_we, acc, carry_we, carry_out}, 11'h203);
		chk(zero_we, 1'b0);
		$display("rotate test done");
	endtask
	task automatic t_ret;
		far.stk[0] = 13'h1abc;
		far.stk[1] = 13'h0123;
		go(CMRR_LITERAL_RETURN_OP, 7'h00, 1'b0, 8'hff);
		chk({carry_we, zero_we, acc}, {2'b00, 8'hff});
		chk({stack_pop, pc}, {1'b1, 13'h1abc});
		chk(busy, 1'b1);
		@(posedge clock);
		#10 chk({busy, stack_pop}, 2'b00);
		go(CMRR_IRQ_RETURN_OP, 7'h00, 1'b0, 8'h00);
		chk({stack_pop, global_irq_allow_set, pc}, {2'b11, 13'h0123});
		chk({carry_we, zero_we}, 2'b00);
		$display("return test done");
	endtask
	task automatic t_idle;
		go(CMRR_IDLE_OP, 7'h05, 1'b1, 8'h00);
		chk({file_we, carry_we, zero_we, stack_pop, busy}, 5'h00);
		chk({acc, global_irq_allow_set}, {8'hff, 1'b0});
		chk(pc, p + CMRR_PC_STEP);
		$display("idle test done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		#10 rst_n = 1'b1;
		t_copy();
		t_rot();
		t_ret();
		t_idle();
		results();
	end
	initial begin
		#100000;
		err_count++;
		results();
	end
endmodule
`default_nettype wire
